// >>> msb_consts.svh
// Constants of the store bus: command codes, address fields, timing.
// Assumes inclusion by bare name from every file of both ends.
`ifndef MSB_CONSTS_SVH
`define MSB_CONSTS_SVH
`define MSB_CMD_READ 4'hC
`define MSB_CMD_WRITE 4'h3
`define MSB_CMD_WP_READ 4'h9
`define MSB_CMD_WP_WRITE 4'h6
`define MSB_CMD_BLIND 4'h5
`define MSB_CMD_SPARE 4'hA
`define MSB_STORE_HI 19
`define MSB_STORE_LO 18
`define MSB_MOD_HI 17
`define MSB_MOD_LO 15
`define MSB_APU_LO 8
`define MSB_APL_HI 7
`define MSB_BLOCK_LO 12
`define MSB_WORD_AW 15
`define MSB_PLANES 13
`define MSB_WP_BITS 64
`define MSB_WP_QUARTER 16
`define MSB_SETTLE_NS 40
`define MSB_CLK_NS 50
`define MSB_SETTLE_CYC ((`MSB_SETTLE_NS + `MSB_CLK_NS - 1) / `MSB_CLK_NS)
`define MSB_REG_CTRL 8'h00
`define MSB_REG_ADDR 8'h04
`define MSB_REG_WDATA 8'h08
`define MSB_REG_RDATA 8'h0C
`define MSB_REG_STATUS 8'h10
`endif

// >>> msb_pkg.sv
// Types shared by both ends of the store bus.
// Assumes nothing of its surroundings.
package msb_pkg;
   typedef logic [3:0] cmd_t;
   typedef logic [19:0] addr_t;
   typedef logic [23:0] data_t;
   typedef enum logic [2:0] {S_IDLE, S_SETTLE, S_ACCESS, S_HOLD, S_IGNORE}
      store_state_e;
   typedef enum logic [1:0] {H_IDLE, H_WAIT, H_DROP} cpu_state_e;
endpackage : msb_pkg

// >>> store_bus_if.sv
// Store bus between the processor end and one store end.
// Assumes both ends run on the same pclk; the shared data leads are
// resolved here from the two active-low output enables.
`timescale 1ns/1ps
interface store_bus_if;
   logic request_strobe;
   logic [3:0] command_leads;
   logic [19:0] address_leads;
   logic address_parity_upper;
   logic address_parity_lower;
   logic invert_rewrite_request;
   logic auto_invert_request;
   logic bus_hold_request;
   logic [26:0] cpu_drive;
   logic cpu_oe_n;
   logic [26:0] store_drive;
   logic store_oe_n;
   logic cycle_done;
   logic fatal_fault_flag;
   logic protect_violation_flag;
   logic read_parity_flag;
   logic [23:0] data_leads;
   logic data_parity_lower;
   logic data_parity_upper;
   logic extended_parity_upper;
   // Bit order of a drive word: {extended upper, upper, lower, data}.
   assign {extended_parity_upper, data_parity_upper, data_parity_lower,
      data_leads} = !store_oe_n ? store_drive :
      (!cpu_oe_n ? cpu_drive : 27'h0000000);
   modport cpu (output request_strobe, command_leads, address_leads,
      address_parity_upper, address_parity_lower, invert_rewrite_request,
      auto_invert_request, bus_hold_request, cpu_drive, cpu_oe_n,
      input cycle_done, fatal_fault_flag, protect_violation_flag,
      read_parity_flag, data_leads, data_parity_lower, data_parity_upper,
      extended_parity_upper);
   modport store (input request_strobe, command_leads, address_leads,
      address_parity_upper, address_parity_lower, invert_rewrite_request,
      auto_invert_request, bus_hold_request, data_leads, data_parity_lower,
      data_parity_upper, extended_parity_upper,
      output store_drive, store_oe_n, cycle_done, fatal_fault_flag,
      protect_violation_flag, read_parity_flag);
endinterface : store_bus_if

// >>> store_end.sv
// Store end of the store bus: command decode, checks, protect map, planes.
// Assumes synchronous bus inputs on pclk and a refresh engine elsewhere.
//
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "msb_consts.svh"
module store_end #(
   parameter logic [1:0] STORE_ID = 2'h0,
   parameter logic [7:0] EQUIPPED = 8'h01,
   parameter int WORD_AW = `MSB_WORD_AW
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Processor side.
   store_bus_if.store bus,
   // Chain toward lower stores, and refresh.
   input wire logic higher_selected,
   input wire logic refresh_active,
   output logic store_selected
);
   localparam int DEPTH = 8 * (2 ** WORD_AW);
   localparam int IW = WORD_AW + 3;

   // The protect map indexes word bits from 12 up, so shorter words fail.
   if (WORD_AW < `MSB_BLOCK_LO || WORD_AW > `MSB_WORD_AW)
   begin : g_bad_aw
      $error("WORD_AW must lie between 12 and 15.");
   end
   if (STORE_ID == 2'h3)
   begin : g_bad_id
      $error("STORE_ID must select one of three stores.");
   end

   msb_pkg::store_state_e state_q;
   logic [3:0] settle_q;
   msb_pkg::cmd_t cmd_q;
   msb_pkg::addr_t addr_q;
   logic [26:0] wbus_q;
   logic apu_q, apl_q, inv_q, auto_q;
   logic [25:0] last_q;
   logic [IW-1:0] last_idx_q;
   logic [`MSB_WP_BITS-1:0] wp_q;
   logic [26:0] rdata_q;
   logic rd_drive_q, done_q, a_q, b_q, c_q;
   logic [IW-1:0] idx;
   logic [25:0] wr_word;
   wire [25:0] rd_word;
   logic wr_en, cmd_bad, par_bad, wpar_bad, unequip, fatal, prot;
   logic pl_err, ph_err;
   logic [25:0] rd_fix;
   logic [1:0] quarter;
   logic [23:0] out_word;

   // Each plane keeps two bits of every word of every module.
   for (genvar p = 0; p < `MSB_PLANES; p++)
   begin : g_plane
      localparam int LO = p < 8 ? p : (p < 12 ? p + 8 : 24);
      localparam int HI = p < 8 ? p + 8 : (p < 12 ? p + 12 : 25);
      logic [1:0] cell_q [DEPTH];
      always_ff @(posedge pclk)
      begin
         if (wr_en)
         begin
            cell_q[idx] <= {wr_word[HI], wr_word[LO]};
         end
      end
      assign rd_word[LO] = cell_q[idx][0];
      assign rd_word[HI] = cell_q[idx][1];
   end

   always_comb
   begin
      quarter = addr_q[1:0];
      // Module from bits 15-17, word from row/column and chip bits.
      idx = {addr_q[`MSB_MOD_HI:`MSB_MOD_LO], addr_q[WORD_AW-1:0]};
      if (cmd_q == `MSB_CMD_WRITE && inv_q)
      begin
         idx = last_idx_q;
      end
      cmd_bad = ($countones(cmd_q) != 2) ||
         (inv_q && cmd_q == `MSB_CMD_READ);
      par_bad = !(^{apu_q, addr_q[19:`MSB_APU_LO]}) ||
         !(^{apl_q, addr_q[`MSB_APL_HI:0]});
      wpar_bad = !(^{wbus_q[24], wbus_q[7:0]}) ||
         !(^{wbus_q[25], wbus_q[15:8]}) || !(^{wbus_q[26], wbus_q[23:16]});
      if (!(cmd_q == `MSB_CMD_WRITE || cmd_q == `MSB_CMD_WP_WRITE) ||
         (cmd_q == `MSB_CMD_WRITE && inv_q))
      begin
         wpar_bad = 1'b0;
      end
      unequip = !EQUIPPED[idx[IW-1:WORD_AW]];
      fatal = cmd_bad || par_bad || wpar_bad || unequip;
      prot = wp_q[idx[IW-1:`MSB_BLOCK_LO]];
      // Stored parity is odd over each half of the twelve bit planes.
      if (inv_q)
      begin
         wr_word = ~last_q;
      end
      else
      begin
         wr_word = {~^{wbus_q[23:20], wbus_q[15:8]},
            ~^{wbus_q[19:16], wbus_q[7:0]}, wbus_q[23:0]};
      end
      wr_en = state_q == msb_pkg::S_ACCESS && cmd_q == `MSB_CMD_WRITE &&
         !fatal && !prot;
      pl_err = !(^{rd_word[24], rd_word[19:16], rd_word[7:0]});
      ph_err = !(^{rd_word[25], rd_word[23:20], rd_word[15:8]});
      rd_fix = (pl_err && ph_err && auto_q) ? ~rd_word : rd_word;
      if (cmd_q == `MSB_CMD_WP_READ)
      begin
         out_word = {8'h00,
            wp_q[quarter * `MSB_WP_QUARTER +: `MSB_WP_QUARTER]};
      end
      else
      begin
         out_word = rd_fix[23:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q <= msb_pkg::S_IDLE;
         settle_q <= 4'h0;
         store_selected <= 1'b0;
      end
      else
      begin
         unique case (state_q)
            msb_pkg::S_IDLE:
            begin
               if (bus.request_strobe && !higher_selected &&
                  !refresh_active)
               begin
                  state_q <= msb_pkg::S_SETTLE;
                  settle_q <= 4'h0;
               end
            end
            msb_pkg::S_SETTLE:
            begin
               // Leads may trail the strobe, so wait before latching.
               settle_q <= settle_q + 4'h1;
               if (settle_q + 4'h1 >= 4'(`MSB_SETTLE_CYC))
               begin
                  if (bus.address_leads[`MSB_STORE_HI:`MSB_STORE_LO] ==
                     STORE_ID)
                  begin
                     state_q <= msb_pkg::S_ACCESS;
                     store_selected <= 1'b1;
                  end
                  else
                  begin
                     state_q <= msb_pkg::S_IGNORE;
                  end
               end
            end
            msb_pkg::S_ACCESS:
            begin
               state_q <= msb_pkg::S_HOLD;
            end
            msb_pkg::S_HOLD, msb_pkg::S_IGNORE:
            begin
               if (!bus.request_strobe)
               begin
                  state_q <= msb_pkg::S_IDLE;
                  store_selected <= 1'b0;
               end
            end
         endcase
      end
   end

   // Leads are latched once, after settling, and held for the cycle.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cmd_q <= 4'h0;
         addr_q <= 20'h00000;
         wbus_q <= 27'h0000000;
         {apu_q, apl_q, inv_q, auto_q} <= 4'h0;
      end
      else if (state_q == msb_pkg::S_SETTLE)
      begin
         cmd_q <= bus.command_leads;
         addr_q <= bus.address_leads;
         wbus_q <= {bus.extended_parity_upper, bus.data_parity_upper,
            bus.data_parity_lower, bus.data_leads};
         apu_q <= bus.address_parity_upper;
         apl_q <= bus.address_parity_lower;
         inv_q <= bus.invert_rewrite_request;
         auto_q <= bus.auto_invert_request;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         last_q <= 26'h0000000;
         last_idx_q <= '0;
      end
      else if (state_q == msb_pkg::S_ACCESS && cmd_q == `MSB_CMD_READ &&
         !fatal)
      begin
         last_q <= rd_word;
         last_idx_q <= idx;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wp_q <= '0;
      end
      else if (state_q == msb_pkg::S_ACCESS &&
         cmd_q == `MSB_CMD_WP_WRITE && !fatal)
      begin
         wp_q[quarter * `MSB_WP_QUARTER +: `MSB_WP_QUARTER] <=
            wbus_q[`MSB_WP_QUARTER-1:0];
      end
   end

   // Answer flags stand from the access until the strobe is dropped.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         {done_q, a_q, b_q, c_q, rd_drive_q} <= 5'h00;
         rdata_q <= 27'h0000000;
      end
      else if (state_q == msb_pkg::S_ACCESS)
      begin
         a_q <= fatal;
         b_q <= !fatal && cmd_q == `MSB_CMD_WRITE && prot;
         c_q <= !fatal && cmd_q == `MSB_CMD_READ &&
            (pl_err || ph_err) && !(pl_err && ph_err && auto_q);
         done_q <= fatal || cmd_q != `MSB_CMD_READ || !(pl_err || ph_err) ||
            (pl_err && ph_err && auto_q);
         rd_drive_q <= !fatal && (cmd_q == `MSB_CMD_READ ||
            cmd_q == `MSB_CMD_WP_READ);
         // Bus parities are made afresh for whatever word goes out.
         rdata_q <= {~^out_word[23:16], ~^out_word[15:8], ~^out_word[7:0],
            out_word};
      end
      else if (state_q == msb_pkg::S_HOLD && !bus.request_strobe)
      begin
         {done_q, a_q, b_q, c_q, rd_drive_q} <= 5'h00;
      end
   end

   assign bus.store_drive = rdata_q;
   assign bus.store_oe_n = !rd_drive_q;
   assign bus.cycle_done = done_q;
   assign bus.fatal_fault_flag = a_q;
   assign bus.protect_violation_flag = b_q;
   assign bus.read_parity_flag = c_q;
endmodule : store_end

// >>> cpu_end.sv
// Processor end of the store bus, ordered by software over APB.
// Assumes an APB master on pclk and one or more stores on the bus.
`timescale 1ns/1ps
`include "msb_consts.svh"
module cpu_end (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Store bus.
   store_bus_if.cpu bus
);
   msb_pkg::cpu_state_e state_q;
   logic [7:0] ctrl_q;
   msb_pkg::addr_t addr_q;
   msb_pkg::data_t wdata_q, rdata_q;
   logic [3:0] flags_q;
   logic strobe_q, oe_q, apu_q, apl_q;
   logic [19:0] lead_addr_q;
   logic [26:0] lead_data_q;
   logic wr, go;

   assign wr = psel && penable && pwrite;
   assign go = wr && paddr == `MSB_REG_CTRL && pwdata[0] &&
      state_q == msb_pkg::H_IDLE;
   assign pready = 1'b1;
   assign pslverr = 1'b0;

   always_comb
   begin
      unique case (paddr)
         `MSB_REG_CTRL: prdata = {24'h000000, ctrl_q};
         `MSB_REG_ADDR: prdata = {12'h000, addr_q};
         `MSB_REG_WDATA: prdata = {8'h00, wdata_q};
         `MSB_REG_RDATA: prdata = {8'h00, rdata_q};
         `MSB_REG_STATUS: prdata = {27'h0000000, flags_q,
            state_q != msb_pkg::H_IDLE};
         default: prdata = 32'h00000000;
      endcase
   end

   // Order registers; the go bit is a command and is never stored.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_q <= 8'h00;
         addr_q <= 20'h00000;
         wdata_q <= 24'h000000;
      end
      else if (wr)
      begin
         if (paddr == `MSB_REG_CTRL)
         begin
            ctrl_q <= {pwdata[7:1], 1'b0};
         end
         if (paddr == `MSB_REG_ADDR)
         begin
            addr_q <= pwdata[19:0];
         end
         if (paddr == `MSB_REG_WDATA)
         begin
            wdata_q <= pwdata[23:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q <= msb_pkg::H_IDLE;
         strobe_q <= 1'b0;
         oe_q <= 1'b0;
         lead_addr_q <= 20'h00000;
         lead_data_q <= 27'h0000000;
         {apu_q, apl_q} <= 2'h0;
         rdata_q <= 24'h000000;
         flags_q <= 4'h0;
      end
      else
      begin
         unique case (state_q)
            msb_pkg::H_IDLE:
            begin
               // All leads change with the strobe, well inside 40 ns.
               if (go)
               begin
                  state_q <= msb_pkg::H_WAIT;
                  strobe_q <= 1'b1;
                  lead_addr_q <= addr_q;
                  apu_q <= ~^addr_q[19:`MSB_APU_LO];
                  apl_q <= ~^addr_q[`MSB_APL_HI:0];
                  lead_data_q <= {~^wdata_q[23:16], ~^wdata_q[15:8],
                     ~^wdata_q[7:0], wdata_q};
                  oe_q <= pwdata[7:4] == `MSB_CMD_WRITE ||
                     pwdata[7:4] == `MSB_CMD_WP_WRITE;
                  flags_q <= 4'h0;
               end
            end
            msb_pkg::H_WAIT:
            begin
               // Strobe stands until completion or error C comes back.
               if (bus.cycle_done || bus.read_parity_flag)
               begin
                  state_q <= msb_pkg::H_DROP;
                  strobe_q <= 1'b0;
                  oe_q <= 1'b0;
                  rdata_q <= bus.data_leads;
                  flags_q <= {bus.read_parity_flag,
                     bus.protect_violation_flag, bus.fatal_fault_flag,
                     bus.cycle_done};
               end
            end
            msb_pkg::H_DROP:
            begin
               if (!bus.cycle_done && !bus.read_parity_flag &&
                  !bus.fatal_fault_flag && !bus.protect_violation_flag)
               begin
                  state_q <= msb_pkg::H_IDLE;
               end
            end
         endcase
      end
   end

   assign bus.request_strobe = strobe_q;
   assign bus.command_leads = ctrl_q[7:4];
   assign bus.address_leads = lead_addr_q;
   assign bus.address_parity_upper = apu_q;
   assign bus.address_parity_lower = apl_q;
   assign bus.invert_rewrite_request = ctrl_q[1];
   assign bus.auto_invert_request = ctrl_q[2];
   assign bus.bus_hold_request = ctrl_q[3];
   assign bus.cpu_drive = lead_data_q;
   assign bus.cpu_oe_n = !oe_q;
endmodule : cpu_end

// >>> main_store_bus_port_monitor.sv
// Checker of the store bus between the processor end and store 0.
// Assumes one clock, pclk, and that only store 0 is ever addressed.
`timescale 1ns/1ps
module main_store_bus_port_monitor (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Processor to store.
   input wire logic request_strobe,
   input wire logic [19:0] address_leads,
   input wire logic address_parity_upper,
   input wire logic address_parity_lower,
   input wire logic cpu_oe_n,
   // Store to processor.
   input wire logic store_oe_n,
   input wire logic cycle_done,
   input wire logic fatal_fault_flag,
   input wire logic protect_violation_flag,
   input wire logic read_parity_flag,
   input wire logic [23:0] data_leads,
   input wire logic data_parity_lower,
   input wire logic data_parity_upper,
   input wire logic extended_parity_upper,
   // Chain and refresh.
   input wire logic higher_selected,
   input wire logic refresh_active,
   input wire logic store_selected
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   AST_ANSWER_TIME:
   assert property ($rose(request_strobe) && !refresh_active &&
      !higher_selected && address_leads[19:18] == 2'h0 |-> !cycle_done
      ##1 !cycle_done ##1 !cycle_done ##1 (cycle_done || read_parity_flag))
      else $error("answer not three edges after strobe");
   AST_DONE_CLEAR:
   assert property (cycle_done && !request_strobe |=> !cycle_done)
      else $error("done outlived strobe");
   AST_STROBE_DROP:
   assert property ($fell(request_strobe) |->
      $past(cycle_done) || $past(read_parity_flag))
      else $error("strobe dropped before answer");
   AST_C_ALONE:
   assert property (!(read_parity_flag && cycle_done))
      else $error("error C together with done");
   AST_A_WITH_DONE:
   assert property (fatal_fault_flag |-> cycle_done)
      else $error("error A without done");
   AST_B_WITH_DONE:
   assert property (protect_violation_flag |-> cycle_done && store_oe_n)
      else $error("error B without done or with data drive");
   AST_ONE_DRIVER:
   assert property (!(!store_oe_n && !cpu_oe_n))
      else $error("both ends drive the data leads");
   AST_ADDR_PARITY:
   assert property (request_strobe |-> ^{address_leads[19:8],
      address_parity_upper} && ^{address_leads[7:0], address_parity_lower})
      else $error("address parity not odd");
   AST_LEADS_HELD:
   assert property (request_strobe && $past(request_strobe) |->
      $stable(address_leads))
      else $error("address moved under strobe");
   AST_BLOCKED:
   assert property (((refresh_active && $past(refresh_active)) ||
      (higher_selected && $past(higher_selected))) && !store_selected
      |=> !store_selected)
      else $error("store selected while blocked");
   AST_SEL_HOLD:
   assert property (store_selected && request_strobe |=> store_selected)
      else $error("selection lost under strobe");
   AST_READ_PARITY:
   assert property (!store_oe_n |-> ^{data_leads[7:0], data_parity_lower} &&
      ^{data_leads[15:8], data_parity_upper} &&
      ^{data_leads[23:16], extended_parity_upper})
      else $error("read data parity not odd");
endmodule : main_store_bus_port_monitor

// >>> main_store_bus_port_tb.sv
// Bench for the processor end and store 0 joined by the store bus.
// Assumes the hand-over timing of both ends; software speaks APB.
`timescale 1ns/1ps
`include "msb_consts.svh"
module main_store_bus_port_tb;
   logic pclk;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic higher_selected;
   logic refresh_active;
   logic store_selected;
   logic [31:0] rd;
   logic [31:0] st;
   int miscompares;
   int check_count;
   store_bus_if store_bus_if_inst ();
   cpu_end cpu_end_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .bus(store_bus_if_inst.cpu));
   store_end store_end_inst (.pclk(pclk), .presetn(presetn),
      .bus(store_bus_if_inst.store), .higher_selected(higher_selected),
      .refresh_active(refresh_active), .store_selected(store_selected));
   main_store_bus_port_monitor main_store_bus_port_monitor_inst (
      .pclk(pclk), .presetn(presetn),
      .request_strobe(store_bus_if_inst.request_strobe),
      .address_leads(store_bus_if_inst.address_leads),
      .address_parity_upper(store_bus_if_inst.address_parity_upper),
      .address_parity_lower(store_bus_if_inst.address_parity_lower),
      .cpu_oe_n(store_bus_if_inst.cpu_oe_n),
      .store_oe_n(store_bus_if_inst.store_oe_n),
      .cycle_done(store_bus_if_inst.cycle_done),
      .fatal_fault_flag(store_bus_if_inst.fatal_fault_flag),
      .protect_violation_flag(store_bus_if_inst.protect_violation_flag),
      .read_parity_flag(store_bus_if_inst.read_parity_flag),
      .data_leads(store_bus_if_inst.data_leads),
      .data_parity_lower(store_bus_if_inst.data_parity_lower),
      .data_parity_upper(store_bus_if_inst.data_parity_upper),
      .extended_parity_upper(store_bus_if_inst.extended_parity_upper),
      .higher_selected(higher_selected), .refresh_active(refresh_active),
      .store_selected(store_selected));
   initial
   begin
      pclk = 1'h0;
      forever #25 pclk = ~pclk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do
         @(posedge pclk);
      while (pready !== 1'h1);
      rd = prdata;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb
   // Flags are {hold request, auto invert, invert rewrite}.
   task automatic go(input logic [3:0] c, input logic [2:0] f,
      input logic [19:0] a, input logic [23:0] d);
      apb(1'h1, `MSB_REG_ADDR, {12'h000, a});
      apb(1'h1, `MSB_REG_WDATA, {8'h00, d});
      apb(1'h1, `MSB_REG_CTRL, {24'h000000, c, f, 1'h1});
      for (int i = 0; i < 8 && store_bus_if_inst.request_strobe !== 1'h1; i++)
         @(posedge pclk);
      chk({30'h0, store_bus_if_inst.address_parity_upper,
         store_bus_if_inst.address_parity_lower},
         {30'h0, ~^a[19:8], ~^a[7:0]});
      chk({31'h0, store_bus_if_inst.bus_hold_request}, {31'h0, f[2]});
      if (c == `MSB_CMD_WRITE && f[0] == 1'h0)
         chk({8'h00, store_bus_if_inst.data_leads}, {8'h00, d});
   endtask : go
   // Polling is bounded so that a store that never answers shows as busy.
   task automatic fin();
      int n;
      n = 0;
      st = 32'h00000001;
      while (st[0] !== 1'h0 && n < 60)
      begin
         apb(1'h0, `MSB_REG_STATUS, 32'h00000000);
         st = rd;
         n++;
      end
      apb(1'h0, `MSB_REG_RDATA, 32'h00000000);
   endtask : fin
   task automatic t_rw();
      go(`MSB_CMD_WRITE, 3'h0, 20'h01234, 24'hA5C3F0);
      fin();
      chk(st, 32'h00000002);
      go(`MSB_CMD_READ, 3'h4, 20'h01234, 24'h000000);
      fin();
      chk(st, 32'h00000002);
      chk(rd, 32'h00A5C3F0);
   endtask : t_rw
   task automatic t_cmds();
      logic [31:0] e;
      for (int c = 0; c < 16; c++)
      begin
         e = ($countones(c[3:0]) != 2) ? 32'h00000006 : 32'h00000002;
         if (e == 32'h00000006 || c == 5 || c == 10)
         begin
            go(c[3:0], 3'h0, 20'h00100, 24'h000000);
            fin();
            chk(st, e);
         end
      end
      go(`MSB_CMD_READ, 3'h0, 20'h08000, 24'h000000);
      fin();
      chk(st, 32'h00000006);
      go(`MSB_CMD_READ, 3'h1, 20'h01234, 24'h000000);
      fin();
      chk(st, 32'h00000006);
   endtask : t_cmds
   task automatic t_protect();
      go(`MSB_CMD_WRITE, 3'h0, 20'h00003, 24'h123456);
      fin();
      go(`MSB_CMD_WP_WRITE, 3'h0, 20'h00000, 24'h000001);
      fin();
      chk(st, 32'h00000002);
      go(`MSB_CMD_WRITE, 3'h0, 20'h00003, 24'h654321);
      fin();
      chk(st, 32'h0000000A);
      go(`MSB_CMD_READ, 3'h0, 20'h00003, 24'h000000);
      fin();
      chk(rd, 32'h00123456);
      go(`MSB_CMD_WP_READ, 3'h0, 20'h00000, 24'h000000);
      fin();
      chk(rd, 32'h00000001);
      go(`MSB_CMD_WP_WRITE, 3'h0, 20'h00000, 24'h000000);
      fin();
   endtask : t_protect
   task automatic t_invert();
      go(`MSB_CMD_READ, 3'h0, 20'h01234, 24'h000000);
      fin();
      go(`MSB_CMD_WRITE, 3'h1, 20'h01234, 24'h000000);
      fin();
      chk(st, 32'h00000002);
      go(`MSB_CMD_READ, 3'h0, 20'h01234, 24'h000000);
      fin();
      chk(st, 32'h00000010);
      go(`MSB_CMD_READ, 3'h2, 20'h01234, 24'h000000);
      fin();
      chk(st, 32'h00000002);
      chk(rd, 32'h00A5C3F0);
   endtask : t_invert
   task automatic t_wait();
      for (int k = 0; k < 2; k++)
      begin
         refresh_active <= (k == 0);
         higher_selected <= (k == 1);
         // The word now lies inverted, so it is read with auto invert.
         go(`MSB_CMD_READ, 3'h2, 20'h01234, 24'h000000);
         repeat (10) @(posedge pclk);
         chk({31'h0, store_selected}, 32'h00000000);
         apb(1'h0, `MSB_REG_STATUS, 32'h00000000);
         chk(rd, 32'h00000001);
         refresh_active <= 1'h0;
         higher_selected <= 1'h0;
         fin();
         chk(rd, 32'h00A5C3F0);
      end
   endtask : t_wait
   task automatic test_done();
      $display("Checks %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : test_done
   initial
   begin
      #1000000;
      miscompares++;
      test_done();
   end
   initial
   begin
      presetn = 1'h0;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      higher_selected = 1'h0;
      refresh_active = 1'h0;
      miscompares = 0;
      check_count = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'h1;
      t_rw();
      t_cmds();
      t_protect();
      t_invert();
      t_wait();
      test_done();
   end
endmodule : main_store_bus_port_tb
